// File: dprm_consts.svh
// Register offsets, reset values, field positions and encodings for the reference monitor register bank
`ifndef DPRM_CONSTS_SVH
`define DPRM_CONSTS_SVH

// Byte offsets on the host port
`define DPRM_ADDR_QWAIT 8'h14
`define DPRM_ADDR_VSEL 8'h15
`define DPRM_ADDR_VIEW0 8'h16
`define DPRM_ADDR_VIEW1 8'h17
`define DPRM_ADDR_ACT0 8'h18
`define DPRM_ADDR_ACT1 8'h19
`define DPRM_ADDR_QUAL0 8'h1a
`define DPRM_ADDR_QUAL1 8'h1b
`define DPRM_ADDR_MODE 8'h1c
`define DPRM_ADDR_BW 8'h1d
`define DPRM_ADDR_AUTO 8'h1e
`define DPRM_ADDR_MANUAL 8'h1f
`define DPRM_ADDR_LONG0 8'h24
`define DPRM_ADDR_LONG3 8'h27
`define DPRM_ADDR_SHORT0 8'h28
`define DPRM_ADDR_SHORT3 8'h2b
`define DPRM_ADDR_USER0 8'h2c
`define DPRM_ADDR_USER3 8'h2f
`define DPRM_ADDR_RAMP 8'h30

// Reset values
`define DPRM_RST_QWAIT 8'h0a
`define DPRM_RST_VSEL 4'h1
`define DPRM_RST_MODE 6'h00
`define DPRM_RST_BW 5'h06
`define DPRM_RST_MANUAL 4'h0
`define DPRM_RST_USER 32'h00000000
`define DPRM_RST_RAMP 7'h26

// Mode register fields
`define DPRM_MODE_PHASE 0
`define DPRM_MODE_USER 2
`define DPRM_MODE_REVERT 3
`define DPRM_MODE_AUTO 4
`define DPRM_MODE_OOP 5

// Holdover register fields
`define DPRM_RAMP_LONG_HI 6
`define DPRM_RAMP_LONG_LO 4
`define DPRM_RAMP_SHORT_HI 3
`define DPRM_RAMP_SHORT_LO 2
`define DPRM_RAMP_LIM_HI 1
`define DPRM_RAMP_LIM_LO 0

// Input numbering and manual choice encoding
`define DPRM_INPUTS 12
`define DPRM_STATUS_W 15
`define DPRM_INPUT_FIRST 4'h1
`define DPRM_INPUT_LAST 4'hc
`define DPRM_MANUAL_FREERUN 4'h0

`endif

// File: dprm_pkg.sv
// Types shared by the reference monitor register bank
`default_nettype none
package dprm_pkg;
  // Action that the manual choice asks of the primary clock generator
  typedef enum logic [2:0] {
    DPRM_ACT_FREERUN = 3'b001,
    DPRM_ACT_REF = 3'b010,
    DPRM_ACT_HOLDOVER = 3'b100
  } dprm_action_e;
endpackage : dprm_pkg
`default_nettype wire

// File: dprm_input_pick.sv
// Registered selection of one reference input's offset and rate code
`include "dprm_consts.svh"
`default_nettype none
module dprm_input_pick (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Input number, 1 to 12
  input wire logic [3:0] inputNum,
  // Per-input status: [11:0] offset, [14:12] rate code
  input wire logic [`DPRM_INPUTS*`DPRM_STATUS_W-1:0] statusBus,
  // Picked values
  output logic [11:0] offset,
  output logic [2:0] rateCode
);
  logic [`DPRM_STATUS_W-1:0] statusArr [`DPRM_INPUTS];
  logic [`DPRM_STATUS_W-1:0] pickD;

  // Split the flat bus per input
  genvar gi;
  generate
    for (gi = 0; gi < `DPRM_INPUTS; gi++) begin : g_split
      assign statusArr[gi] = statusBus[gi*`DPRM_STATUS_W +: `DPRM_STATUS_W];
    end
  endgenerate

  // Numbers outside 1 to 12 show no signal and zero offset
  always_comb begin
    pickD = '0;
    if (inputNum >= `DPRM_INPUT_FIRST && inputNum <= `DPRM_INPUT_LAST) begin
      pickD = statusArr[inputNum - `DPRM_INPUT_FIRST];
    end
  end

  // One cycle of latency, so the caller sees a stable value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      offset <= 12'h000;
      rateCode <= 3'h0;
    end else begin
      offset <= pickD[11:0];
      rateCode <= pickD[14:12];
    end
  end
endmodule : dprm_input_pick
`default_nettype wire

// File: dprm_regs.sv
// Reference monitor and primary loop control register bank on the byte-wide host port
`include "dprm_consts.svh"
`default_nettype none
module dprm_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host byte port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Monitor status from the core
  input wire logic [`DPRM_INPUTS*`DPRM_STATUS_W-1:0] inputStatus,
  input wire logic [13:0] activity,
  input wire logic [11:0] qualified,
  input wire logic [3:0] autoChoice,
  input wire logic [3:0] mateChoice,
  input wire logic isMaster,
  input wire logic [31:0] longHistory,
  input wire logic [31:0] shortHistory,
  input wire logic [10:0] pullinLimit,
  // Controls to the primary clock generator
  output logic [7:0] qualifyWait,
  output logic phaseAlign,
  output logic useUserHistory,
  output logic revertive,
  output logic autoSelect,
  output logic outsidePullinFollow,
  output logic [4:0] loopBandwidth,
  output logic [3:0] manualChoice,
  output logic forceFreerun,
  output logic forceHoldover,
  output logic [3:0] manualRef,
  output logic followActive,
  output logic [31:0] holdoverHistory,
  output logic [2:0] longHistBw,
  output logic [1:0] shortHistBw,
  output logic [1:0] rampLimit
);
  logic [3:0] viewSel_q;
  logic [31:0] userHistory_q;
  logic [23:0] userStage_q;
  logic [7:0] viewHiShadow_q;
  logic [23:0] longShadow_q;
  logic [23:0] shortShadow_q;
  logic [11:0] viewOffset;
  logic [2:0] viewRate;
  logic [11:0] refOffset;
  logic [2:0] refRate;
  logic [11:0] refMag;
  logic [3:0] shownChoice;
  logic [7:0] rdData_d;
  logic wrQwait, wrVsel, wrMode, wrBw, wrManual, wrRamp;
  logic wrUser0, wrUser1, wrUser2, wrUser3;
  dprm_pkg::dprm_action_e manualAct;

  // Classify a manual choice; used for the manual action outputs
  function automatic dprm_pkg::dprm_action_e decodeManual(input logic [3:0] choice);
    if (choice == `DPRM_MANUAL_FREERUN) begin
      return dprm_pkg::DPRM_ACT_FREERUN;
    end else if (choice <= `DPRM_INPUT_LAST) begin
      return dprm_pkg::DPRM_ACT_REF;
    end
    return dprm_pkg::DPRM_ACT_HOLDOVER;
  endfunction : decodeManual

  // Write strobes per register
  assign wrQwait = regWr && regAddr == `DPRM_ADDR_QWAIT;
  assign wrVsel = regWr && regAddr == `DPRM_ADDR_VSEL;
  assign wrMode = regWr && regAddr == `DPRM_ADDR_MODE;
  assign wrBw = regWr && regAddr == `DPRM_ADDR_BW;
  assign wrManual = regWr && regAddr == `DPRM_ADDR_MANUAL;
  assign wrRamp = regWr && regAddr == `DPRM_ADDR_RAMP;
  assign wrUser0 = regWr && regAddr == `DPRM_ADDR_USER0;
  assign wrUser1 = regWr && regAddr == `DPRM_ADDR_USER0 + 8'h01;
  assign wrUser2 = regWr && regAddr == `DPRM_ADDR_USER0 + 8'h02;
  assign wrUser3 = regWr && regAddr == `DPRM_ADDR_USER3;
  assign manualAct = decodeManual(manualChoice);

  // Qualification wait, full byte kept so 0 to 255 s all fit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qualifyWait <= `DPRM_RST_QWAIT;
    end else if (wrQwait) begin
      qualifyWait <= regWrData;
    end
  end

  // View selector; out-of-range values are dropped so the view never goes blank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      viewSel_q <= `DPRM_RST_VSEL;
    end else if (wrVsel && regWrData >= {4'h0, `DPRM_INPUT_FIRST} && regWrData <= {4'h0, `DPRM_INPUT_LAST}) begin
      viewSel_q <= regWrData[3:0];
    end
  end

  // Mode bits; bits 1, 6 and 7 are not stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {outsidePullinFollow, autoSelect, revertive, useUserHistory, phaseAlign} <= 5'h00;
    end else if (wrMode) begin
      phaseAlign <= regWrData[`DPRM_MODE_PHASE];
      useUserHistory <= regWrData[`DPRM_MODE_USER];
      revertive <= regWrData[`DPRM_MODE_REVERT];
      autoSelect <= regWrData[`DPRM_MODE_AUTO];
      outsidePullinFollow <= regWrData[`DPRM_MODE_OOP];
    end
  end

  // Bandwidth and manual choice; reserved bandwidth codes are stored as written
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loopBandwidth <= `DPRM_RST_BW;
      manualChoice <= `DPRM_RST_MANUAL;
    end else begin
      if (wrBw) begin
        loopBandwidth <= regWrData[4:0];
      end
      if (wrManual) begin
        manualChoice <= regWrData[3:0];
      end
    end
  end

  // Holdover bandwidths and ramp limit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {longHistBw, shortHistBw, rampLimit} <= `DPRM_RST_RAMP;
    end else if (wrRamp) begin
      longHistBw <= regWrData[`DPRM_RAMP_LONG_HI:`DPRM_RAMP_LONG_LO];
      shortHistBw <= regWrData[`DPRM_RAMP_SHORT_HI:`DPRM_RAMP_SHORT_LO];
      rampLimit <= regWrData[`DPRM_RAMP_LIM_HI:`DPRM_RAMP_LIM_LO];
    end
  end

  // User history: lower bytes are staged and the top byte commits all four,
  // so the core never holds over on a half-written value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      userStage_q <= 24'h000000;
      userHistory_q <= `DPRM_RST_USER;
    end else begin
      if (wrUser0) begin
        userStage_q[7:0] <= regWrData;
      end
      if (wrUser1) begin
        userStage_q[15:8] <= regWrData;
      end
      if (wrUser2) begin
        userStage_q[23:16] <= regWrData;
      end
      if (wrUser3) begin
        userHistory_q <= {regWrData, userStage_q};
      end
    end
  end

  // Holdover frequency source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdoverHistory <= 32'h00000000;
    end else begin
      holdoverHistory <= useUserHistory ? userHistory_q : longHistory;
    end
  end

  // Manual action outputs, all held low in automatic mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      forceFreerun <= 1'b0;
      forceHoldover <= 1'b0;
      manualRef <= 4'h0;
    end else begin
      forceFreerun <= !autoSelect && manualAct == dprm_pkg::DPRM_ACT_FREERUN;
      forceHoldover <= !autoSelect && manualAct == dprm_pkg::DPRM_ACT_HOLDOVER;
      manualRef <= (!autoSelect && manualAct == dprm_pkg::DPRM_ACT_REF) ? manualChoice : 4'h0;
    end
  end

  // Viewed input and manually chosen input
  dprm_input_pick u_view_pick (
    .clk(clk),
    .resetn(resetn),
    .inputNum(viewSel_q),
    .statusBus(inputStatus),
    .offset(viewOffset),
    .rateCode(viewRate)
  );

  dprm_input_pick u_ref_pick (
    .clk(clk),
    .resetn(resetn),
    .inputNum(manualRef),
    .statusBus(inputStatus),
    .offset(refOffset),
    .rateCode(refRate)
  );

  // Offset magnitude; -204.8 ppm gives 2048, which still fits 12 unsigned bits
  assign refMag = refOffset[11] ? 12'(~refOffset + 12'h001) : refOffset;

  // Pull-in check: a manual input beyond the limit is followed only if allowed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      followActive <= 1'b0;
    end else if (autoSelect) begin
      followActive <= 1'b1;
    end else if (manualRef == 4'h0 || refRate == 3'h0) begin
      followActive <= 1'b0;
    end else begin
      followActive <= (refMag <= {1'b0, pullinLimit}) || outsidePullinFollow;
    end
  end

  // Reported active input follows master or slave role
  assign shownChoice = isMaster ? autoChoice : mateChoice;

  // Read mux; unmapped offsets and unused bits return zero
  always_comb begin
    rdData_d = 8'h00;
    case (regAddr)
      `DPRM_ADDR_QWAIT: rdData_d = qualifyWait;
      `DPRM_ADDR_VSEL: rdData_d = {4'h0, viewSel_q};
      `DPRM_ADDR_VIEW0: rdData_d = viewOffset[7:0];
      `DPRM_ADDR_VIEW1: rdData_d = viewHiShadow_q;
      `DPRM_ADDR_ACT0: rdData_d = activity[7:0];
      `DPRM_ADDR_ACT1: rdData_d = {2'h0, activity[13:8]};
      `DPRM_ADDR_QUAL0: rdData_d = qualified[7:0];
      `DPRM_ADDR_QUAL1: rdData_d = {4'h0, qualified[11:8]};
      `DPRM_ADDR_MODE: rdData_d = {2'h0, outsidePullinFollow, autoSelect, revertive, useUserHistory, 1'b0, phaseAlign};
      `DPRM_ADDR_BW: rdData_d = {3'h0, loopBandwidth};
      `DPRM_ADDR_AUTO: rdData_d = {4'h0, shownChoice};
      `DPRM_ADDR_MANUAL: rdData_d = {4'h0, manualChoice};
      `DPRM_ADDR_LONG0: rdData_d = longHistory[7:0];
      `DPRM_ADDR_LONG0 + 8'h01: rdData_d = longShadow_q[7:0];
      `DPRM_ADDR_LONG0 + 8'h02: rdData_d = longShadow_q[15:8];
      `DPRM_ADDR_LONG3: rdData_d = longShadow_q[23:16];
      `DPRM_ADDR_SHORT0: rdData_d = shortHistory[7:0];
      `DPRM_ADDR_SHORT0 + 8'h01: rdData_d = shortShadow_q[7:0];
      `DPRM_ADDR_SHORT0 + 8'h02: rdData_d = shortShadow_q[15:8];
      `DPRM_ADDR_SHORT3: rdData_d = shortShadow_q[23:16];
      `DPRM_ADDR_USER0: rdData_d = userHistory_q[7:0];
      `DPRM_ADDR_USER0 + 8'h01: rdData_d = userHistory_q[15:8];
      `DPRM_ADDR_USER0 + 8'h02: rdData_d = userHistory_q[23:16];
      `DPRM_ADDR_USER3: rdData_d = userHistory_q[31:24];
      `DPRM_ADDR_RAMP: rdData_d = {1'b0, longHistBw, shortHistBw, rampLimit};
      default: rdData_d = 8'h00;
    endcase
  end

  // Reading a low byte freezes the upper bytes, so a multibyte read is coherent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      viewHiShadow_q <= 8'h00;
      longShadow_q <= 24'h000000;
      shortShadow_q <= 24'h000000;
    end else if (regRd) begin
      if (regAddr == `DPRM_ADDR_VIEW0) begin
        viewHiShadow_q <= {1'b0, viewRate, viewOffset[11:8]};
      end
      if (regAddr == `DPRM_ADDR_LONG0) begin
        longShadow_q <= longHistory[31:8];
      end
      if (regAddr == `DPRM_ADDR_SHORT0) begin
        shortShadow_q <= shortHistory[31:8];
      end
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      regRdData <= regRd ? rdData_d : 8'h00;
    end
  end

  // Checks on the bank's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_wait_write: assert property (wrQwait |=> qualifyWait == $past(regWrData))
    else $error("qualification wait not written");
  a_selector_range: assert property (viewSel_q >= `DPRM_INPUT_FIRST && viewSel_q <= `DPRM_INPUT_LAST)
    else $error("view selector outside 1 to 12");
  a_phase_write: assert property (wrMode |=> phaseAlign == $past(regWrData[0]) &&
    useUserHistory == $past(regWrData[2])) else $error("phase or history mode bit not stored");
  a_auto_write: assert property (wrMode |=> autoSelect == $past(regWrData[4]) &&
    revertive == $past(regWrData[3])) else $error("selection mode bits not stored");
  a_holdover_source: assert property (resetn |=> holdoverHistory ==
    ($past(useUserHistory) ? $past(userHistory_q) : $past(longHistory))) else $error("holdover source wrong");
  a_user_commit: assert property (wrUser3 |=> userHistory_q[31:24] == $past(regWrData) &&
    userHistory_q[23:0] == $past(userStage_q)) else $error("user history commit wrong");
  a_freerun_force: assert property (resetn && !autoSelect && manualChoice == 4'h0 && !wrMode && !wrManual
    |=> forceFreerun ##1 forceFreerun || wrMode || wrManual) else $error("freerun not forced");
  a_holdover_force: assert property (!autoSelect && manualChoice > 4'hc |=>
    forceHoldover && !forceFreerun) else $error("holdover not forced");
  a_bw_write: assert property (wrBw |=> loopBandwidth == $past(regWrData[4:0]))
    else $error("bandwidth not stored");
  a_unused_zero: assert property (regRd && regAddr == `DPRM_ADDR_MODE |=> regRdValid &&
    regRdData[7:6] == 2'h0 && !regRdData[1]) else $error("unused mode bits read nonzero");
  a_choice_shown: assert property (regRd && regAddr == `DPRM_ADDR_AUTO |=>
    regRdData[3:0] == $past(shownChoice) && regRdData[7:4] == 4'h0) else $error("reported choice wrong");

  c_user_commit: cover property (wrUser0 ##[1:8] wrUser3);
  c_forced_holdover: cover property (forceHoldover);
  c_view_read: cover property (regRd && regAddr == `DPRM_ADDR_VIEW0 ##1 regRd && regAddr == `DPRM_ADDR_VIEW1);
  c_not_followed: cover property (!autoSelect && manualRef != 4'h0 ##2 !followActive);
endmodule : dprm_regs
`default_nettype wire

// File: dprm_regs_tb_top.sv
// Self-checking testbench for the reference monitor and primary loop control register bank
`include "dprm_consts.svh"
`default_nettype none
module dprm_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // Bench clock, reset and host port
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWr, regRd, regRdValid;
  // Core status driven by the bench
  logic [`DPRM_INPUTS*`DPRM_STATUS_W-1:0] inputStatus;
  logic [13:0] activity;
  logic [11:0] qualified;
  logic [3:0] autoChoice, mateChoice, manualChoice, manualRef;
  logic isMaster;
  logic [31:0] longHistory, shortHistory, holdoverHistory;
  logic [10:0] pullinLimit;
  // Controls observed at the outputs
  logic [7:0] qualifyWait;
  logic phaseAlign, useUserHistory, revertive, autoSelect, outsidePullinFollow;
  logic forceFreerun, forceHoldover, followActive;
  logic [4:0] loopBandwidth;
  logic [2:0] longHistBw;
  logic [1:0] shortHistBw, rampLimit;
  int fails = 0;
  int checkCount = 0;
  int cycles = 0;
  // Ordinary write-then-read cases: address, written byte, byte read back
  logic [7:0] rowAddr [12] = '{8'h14, 8'h14, 8'h15, 8'h15, 8'h15, 8'h1c, 8'h1d, 8'h1d, 8'h1f, 8'h30, 8'h21, 8'h17};
  logic [7:0] rowData [12] = '{8'hff, 8'h3f, 8'h0c, 8'h0d, 8'h00, 8'hff, 8'h1f, 8'hab, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] rowExp [12] = '{8'hff, 8'h3f, 8'h0c, 8'h0c, 8'h0c, 8'h3d, 8'h1f, 8'h0b, 8'h0f, 8'h7f, 8'h00, 8'h00};
  // Registers that must hold their reset value, then the byte expected
  logic [7:0] rstAddr [10] = '{8'h14, 8'h15, 8'h1c, 8'h1d, 8'h1f, 8'h2c, 8'h2d, 8'h2f, 8'h30, 8'h20};
  logic [7:0] rstExp [10] = '{8'h0a, 8'h01, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h26, 8'h00};
  int modeBit [5] = '{0, 2, 3, 4, 5};
  // Status word of the input under test, so its fields can be sliced
  logic [14:0] stat;

  dprm_regs u_dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .regRdValid(regRdValid), .inputStatus(inputStatus), .activity(activity),
    .qualified(qualified), .autoChoice(autoChoice), .mateChoice(mateChoice), .isMaster(isMaster),
    .longHistory(longHistory), .shortHistory(shortHistory), .pullinLimit(pullinLimit),
    .qualifyWait(qualifyWait), .phaseAlign(phaseAlign), .useUserHistory(useUserHistory),
    .revertive(revertive), .autoSelect(autoSelect), .outsidePullinFollow(outsidePullinFollow),
    .loopBandwidth(loopBandwidth), .manualChoice(manualChoice), .forceFreerun(forceFreerun),
    .forceHoldover(forceHoldover), .manualRef(manualRef), .followActive(followActive),
    .holdoverHistory(holdoverHistory), .longHistBw(longHistBw), .shortHistBw(shortHistBw),
    .rampLimit(rampLimit)
  );

  // 20 MHz clock
  always #25 clk = ~clk;

  // Hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks=%0d fails=%0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Waits n edges, then lets that edge's updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // One-cycle write strobe; the lowering edge is the one where the register shows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data and valid stand only in the following cycle
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(32'(regRdValid), 32'h1);
    chk(32'(regRdData), 32'(exp));
  endtask : rdChk

  // Offset and rate code given to input n (0 based); every offset is negative, all eight rate codes are covered
  function automatic logic [14:0] statusOf(input int n);
    logic [11:0] off;
    off = 12'h800 ^ 12'(n * 183);
    return {3'((n + 1) % 8), off};
  endfunction : statusOf

  task automatic resetChecks;
    chk(32'({qualifyWait, loopBandwidth, manualChoice}), 32'({8'h0a, 5'h06, 4'h0}));
    chk(32'({longHistBw, shortHistBw, rampLimit}), 32'({3'h2, 2'h1, 2'h2}));
    chk(32'({phaseAlign, useUserHistory, revertive, autoSelect, outsidePullinFollow}), 32'h0);
    for (int i = 0; i < 10; i++) begin
      rdChk(rstAddr[i], rstExp[i]);
    end
  endtask : resetChecks

  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    for (int n = 0; n < 12; n++) begin
      inputStatus[n*15 +: 15] = statusOf(n);
    end
    activity = 14'h2a5c;
    qualified = 12'hb3c;
    autoChoice = 4'h5;
    mateChoice = 4'h9;
    isMaster = 1'b1;
    longHistory = 32'h89abcdef;
    shortHistory = 32'h10325476;
    pullinLimit = 11'd50;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    resetChecks();
    // Table of ordinary writes and their read-back, refused and reserved cases included
    for (int i = 0; i < 12; i++) begin
      wr(rowAddr[i], rowData[i]);
      rdChk(rowAddr[i], rowExp[i]);
    end
    wr(`DPRM_ADDR_RAMP, 8'h5b);
    cyc(1);
    chk(32'({longHistBw, shortHistBw, rampLimit}), 32'({3'h5, 2'h2, 2'h3}));
    // Each mode bit alone drives its own control
    for (int i = 0; i < 5; i++) begin
      wr(`DPRM_ADDR_MODE, 8'(1 << modeBit[i]));
      cyc(1);
      chk(32'({outsidePullinFollow, autoSelect, revertive, useUserHistory, phaseAlign}), 32'(1 << i));
    end
    // Viewed offset and rate code for every input
    for (int n = 1; n <= 12; n++) begin
      wr(`DPRM_ADDR_VSEL, 8'(n));
      stat = statusOf(n - 1);
      cyc(2);
      rdChk(`DPRM_ADDR_VIEW0, stat[7:0]);
      rdChk(`DPRM_ADDR_VIEW1, {1'b0, stat[14:12], stat[11:8]});
    end
    // Flags read live
    rdChk(`DPRM_ADDR_ACT0, 8'h5c);
    rdChk(`DPRM_ADDR_ACT1, 8'h2a);
    rdChk(`DPRM_ADDR_QUAL0, 8'h3c);
    rdChk(`DPRM_ADDR_QUAL1, 8'h0b);
    rdChk(`DPRM_ADDR_AUTO, 8'h05);
    @(posedge clk);
    isMaster <= 1'b0;
    rdChk(`DPRM_ADDR_AUTO, 8'h09);
    // Back-to-back history reads, one strobe held over four cycles
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= `DPRM_ADDR_LONG0;
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk);
      if (i < 4) begin
        regAddr <= 8'(`DPRM_ADDR_LONG0 + i);
      end else begin
        regRd <= 1'b0;
      end
      #1;
      chk(32'({regRdValid, regRdData}), 32'({1'b1, longHistory[8*(i-1) +: 8]}));
    end
    // High bytes come from the value frozen at the low-byte read
    rdChk(`DPRM_ADDR_SHORT0, 8'h76);
    @(posedge clk);
    shortHistory <= 32'h0;
    rdChk(8'h29, 8'h54);
    rdChk(`DPRM_ADDR_SHORT3, 8'h10);
    // User history is held back until its top byte lands
    wr(`DPRM_ADDR_USER0, 8'h11);
    wr(8'h2d, 8'h22);
    wr(8'h2e, 8'h33);
    rdChk(`DPRM_ADDR_USER0, 8'h00);
    wr(`DPRM_ADDR_USER3, 8'h44);
    for (int i = 0; i < 4; i++) begin
      rdChk(8'(`DPRM_ADDR_USER0 + i), 8'(8'h11 * (i + 1)));
    end
    wr(`DPRM_ADDR_MODE, 8'h04);
    cyc(2);
    chk(holdoverHistory, 32'h44332211);
    wr(`DPRM_ADDR_MODE, 8'h00);
    cyc(2);
    chk(holdoverHistory, 32'h89abcdef);
    // Every manual choice code
    for (int v = 0; v < 16; v++) begin
      wr(`DPRM_ADDR_MANUAL, 8'(v));
      cyc(2);
      chk(32'({forceFreerun, forceHoldover, manualRef}), 32'({v == 0, v > 12, (v > 12) ? 4'h0 : 4'(v)}));
    end
    // Following an input against the pull-in limit, edge of range included
    @(posedge clk);
    inputStatus[2*15 +: 15] <= {3'h3, 12'hf9c};
    wr(`DPRM_ADDR_MANUAL, 8'h03);
    cyc(4);
    chk(32'(followActive), 32'h0);
    wr(`DPRM_ADDR_MODE, 8'h20);
    cyc(4);
    chk(32'(followActive), 32'h1);
    // Input 8 reports no signal, so it is never followed even when out-of-range is allowed
    wr(`DPRM_ADDR_MANUAL, 8'h08);
    cyc(4);
    chk(32'(followActive), 32'h0);
    wr(`DPRM_ADDR_MANUAL, 8'h03);
    wr(`DPRM_ADDR_MODE, 8'h00);
    @(posedge clk);
    inputStatus[2*15 +: 12] <= 12'h032;
    cyc(4);
    chk(32'(followActive), 32'h1);
    @(posedge clk);
    inputStatus[2*15 +: 12] <= 12'h033;
    cyc(4);
    chk(32'(followActive), 32'h0);
    wr(`DPRM_ADDR_MODE, 8'h10);
    cyc(4);
    chk(32'({followActive, forceFreerun, forceHoldover}), 32'h4);
    // Reset again in mid-run
    @(posedge clk);
    resetn <= 1'b0;
    cyc(2);
    @(posedge clk);
    resetn <= 1'b1;
    #1;
    resetChecks();
    final_report();
  end
endmodule : dprm_regs_tb_top
`default_nettype wire
